// ==== hdl/t1_ctrl_pkg.sv ====
// Constants for the T1 framing, alarm and data link control block.
package t1_ctrl_pkg;
  localparam logic [7:0] ADDR_FRAMING = 8'h10;
  localparam logic [7:0] ADDR_ALARM   = 8'h11;
  localparam logic [7:0] ADDR_LINK    = 8'h12;
  localparam logic [7:0] ADDR_MSG     = 8'h13;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_ERRCNT  = 8'h21;
  localparam logic [7:0] FRAMING_RST  = 8'h00;
  localparam logic [7:0] ALARM_RST    = 8'h10;
  localparam logic [7:0] LINK_RST     = 8'h00;
  localparam logic [7:0] MSG_RST      = 8'h00;
  localparam int FM_ESF     = 7;
  localparam int FM_SLC     = 6;
  localparam int FM_RS_HI   = 4;
  localparam int FM_RS_LO   = 3;
  localparam int FM_FSI     = 2;
  localparam int FM_RESYNC  = 1;
  localparam int FM_MF      = 0;
  localparam int AL_ESF_YEL = 7;
  localparam int AL_SEC_TX  = 6;
  localparam int AL_D4_YEL  = 5;
  localparam int AL_ONES_N  = 4;
  localparam int AL_LUP     = 3;
  localparam int AL_LDN     = 2;
  localparam int AL_SEC_MD  = 1;
  localparam int AL_OVR     = 0;
  localparam int LK_EXT     = 7;
  localparam int LK_BMSG    = 6;
  localparam int LK_FDL_H   = 5;
  localparam int LK_CH24_H  = 4;
  localparam int LK_ALIGN   = 3;
  localparam int LK_PASS    = 2;
  localparam int LK_JAPAN   = 1;
  localparam int LK_RATE64  = 0;
  localparam logic [4:0] SEC_FRAME  = 5'h0c;
  localparam logic [4:0] CH24_SLOT  = 5'h17;
  localparam logic [4:0] SYNC_SLOT  = 5'h1f;
  localparam logic [2:0] YEL_BIT    = 3'h1;
  localparam logic [2:0] STUFF_BIT  = 3'h7;
  localparam logic [2:0] LUP_LAST   = 3'h4;
  localparam logic [1:0] LDN_LAST   = 2'h2;
  localparam logic [3:0] YEL_HALF   = 4'h8;
  localparam logic [7:0] MSG_FLAG   = 8'hff;
endpackage : t1_ctrl_pkg

// ==== hdl/t1_ctrl.sv ====
// Framing, transmit alarm and data link control logic of a T1 framer.
`timescale 1ns/100ps
module t1_ctrl (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_tx_bit_en,
  input  wire logic       i_tx_fbit,
  input  wire logic [4:0] i_tx_frame,
  input  wire logic [4:0] i_tx_slot,
  input  wire logic [2:0] i_tx_bit_idx,
  input  wire logic       i_backplane_data_in,
  input  wire logic       i_ext_link_bit,
  input  wire logic       i_fdl_ctrl_bit,
  input  wire logic       i_ch24_ctrl_bit,
  output logic            o_tx_line,
  output logic            o_tx_sbit_stb,
  output logic            o_tx_sbit,
  input  wire logic       i_rx_fbit_en,
  input  wire logic [4:0] i_rx_frame,
  input  wire logic       i_rx_fbit,
  input  wire logic       i_rx_fbit_err,
  input  wire logic       i_mf_sync_ok,
  input  wire logic       i_rx_bit_en,
  input  wire logic       i_rx_line_bit,
  input  wire logic       i_rx_framed_bit,
  output logic            o_backplane_data_out,
  output logic            o_frame_resync,
  output logic            o_mf_resync,
  output logic            o_sig_freeze,
  output logic            o_crc_sbit_include,
  output logic            o_ch24_rate_64
);

  logic [7:0] framing;
  logic [7:0] alarm;
  logic [7:0] link;
  logic [7:0] msg;
  logic [7:0] errcnt;
  logic [4:0] hist;
  logic       sec_flag;
  logic       resync_d;
  logic       mf_d;
  logic [2:0] lup_cnt;
  logic [1:0] ldn_cnt;
  logic [3:0] fdl_cnt;
  logic       next_tx;
  logic [7:0] next_rdata;

  wire esf     = framing[t1_ctrl_pkg::FM_ESF];
  wire slc     = framing[t1_ctrl_pkg::FM_SLC];
  wire pass    = link[t1_ctrl_pkg::LK_PASS];
  wire ones    = !alarm[t1_ctrl_pkg::AL_ONES_N];
  wire lup     = alarm[t1_ctrl_pkg::AL_LUP];
  wire ldn     = alarm[t1_ctrl_pkg::AL_LDN];
  wire ovr     = alarm[t1_ctrl_pkg::AL_OVR];
  wire sec_md  = alarm[t1_ctrl_pkg::AL_SEC_MD];
  wire maint   = ones || lup || ldn;
  wire fdl_pos = i_tx_fbit && esf && i_tx_frame[0];
  wire fs_pos  = i_tx_fbit && !esf && !i_tx_frame[0];
  wire wr_cnt  = i_ce && i_wr && (i_addr == t1_ctrl_pkg::ADDR_ERRCNT);
  wire rd_stat = i_ce && i_rd && (i_addr == t1_ctrl_pkg::ADDR_STATUS);
  wire rx_d4   = !esf && !slc;
  wire rx_f12  = i_rx_frame == t1_ctrl_pkg::SEC_FRAME;
  wire rx_fs   = !i_rx_frame[0];
  wire fs_ok   = framing[t1_ctrl_pkg::FM_FSI] && !(rx_f12 && sec_md);
  wire counted = !rx_fs || esf || (rx_d4 && fs_ok);
  wire err_hit = i_rx_fbit_en && i_rx_fbit_err && counted;
  wire sec_hit = i_rx_fbit_en && !esf && rx_fs && rx_f12 && sec_md && i_rx_fbit;
  logic [4:0] win_mask;
  always_comb begin
    unique case (framing[t1_ctrl_pkg::FM_RS_HI:t1_ctrl_pkg::FM_RS_LO])
      2'h0:    win_mask = 5'h07;
      2'h1:    win_mask = 5'h0f;
      2'h2:    win_mask = 5'h1f;
      2'h3:    win_mask = 5'h00;
    endcase
  end
  wire auto_re = err_hit && |(hist & win_mask);
  wire force_edge = framing[t1_ctrl_pkg::FM_RESYNC] && !resync_d;
  wire mf_edge = framing[t1_ctrl_pkg::FM_MF] && !mf_d && !esf;

  // Control words keep their value until the host writes them again.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      framing <= t1_ctrl_pkg::FRAMING_RST;
      alarm   <= t1_ctrl_pkg::ALARM_RST;
      link    <= t1_ctrl_pkg::LINK_RST;
      msg     <= t1_ctrl_pkg::MSG_RST;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        t1_ctrl_pkg::ADDR_FRAMING: framing <= i_wdata;
        t1_ctrl_pkg::ADDR_ALARM:   alarm   <= i_wdata;
        t1_ctrl_pkg::ADDR_LINK:    link    <= i_wdata;
        t1_ctrl_pkg::ADDR_MSG:     msg     <= i_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (i_addr)
      t1_ctrl_pkg::ADDR_FRAMING: next_rdata = framing;
      t1_ctrl_pkg::ADDR_ALARM:   next_rdata = alarm;
      t1_ctrl_pkg::ADDR_LINK:    next_rdata = link;
      t1_ctrl_pkg::ADDR_MSG:     next_rdata = msg;
      t1_ctrl_pkg::ADDR_STATUS:  next_rdata = {7'h00, sec_flag};
      t1_ctrl_pkg::ADDR_ERRCNT:  next_rdata = errcnt;
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // Loop code counters run on every line bit so each code repeats seamlessly; the data link counter steps only at FDL bits.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lup_cnt <= 3'h0;
      ldn_cnt <= 2'h0;
      fdl_cnt <= 4'h0;
    end else if (i_ce && i_tx_bit_en) begin
      lup_cnt <= (lup_cnt == t1_ctrl_pkg::LUP_LAST) ? 3'h0 : lup_cnt + 3'h1;
      ldn_cnt <= (ldn_cnt == t1_ctrl_pkg::LDN_LAST) ? 2'h0 : ldn_cnt + 2'h1;
      if (fdl_pos) begin
        fdl_cnt <= fdl_cnt + 4'h1;
      end
    end
  end

  wire yel_bit = link[t1_ctrl_pkg::LK_JAPAN] || (fdl_cnt < t1_ctrl_pkg::YEL_HALF);
  wire [15:0] msg_word = {t1_ctrl_pkg::MSG_FLAG, msg};
  wire msg_bit = msg_word[4'hf - fdl_cnt];
  wire maint_bit = ones || (lup ? (lup_cnt == t1_ctrl_pkg::LUP_LAST)
                                : (ldn_cnt == t1_ctrl_pkg::LDN_LAST));
  wire ch24_use = link[t1_ctrl_pkg::LK_CH24_H] && (i_tx_slot == t1_ctrl_pkg::CH24_SLOT)
                  && (link[t1_ctrl_pkg::LK_RATE64] || i_tx_bit_idx != t1_ctrl_pkg::STUFF_BIT);

  always_comb begin
    next_tx = i_backplane_data_in;
    if (!pass) begin
      if (fdl_pos) begin
        if (alarm[t1_ctrl_pkg::AL_ESF_YEL]) begin
          next_tx = yel_bit;
        end else if (link[t1_ctrl_pkg::LK_EXT]) begin
          next_tx = i_ext_link_bit;
        end else if (link[t1_ctrl_pkg::LK_BMSG]) begin
          next_tx = msg_bit;
        end else if (link[t1_ctrl_pkg::LK_FDL_H]) begin
          next_tx = i_fdl_ctrl_bit;
        end
      end else if (fs_pos) begin
        if (link[t1_ctrl_pkg::LK_EXT]) begin
          next_tx = i_ext_link_bit;
        end
        if (alarm[t1_ctrl_pkg::AL_SEC_TX] && i_tx_frame == t1_ctrl_pkg::SEC_FRAME) begin
          next_tx = 1'b1;
        end
      end else if (!i_tx_fbit) begin
        if (ch24_use) begin
          next_tx = i_ch24_ctrl_bit;
        end
        if (alarm[t1_ctrl_pkg::AL_D4_YEL] && i_tx_bit_idx == t1_ctrl_pkg::YEL_BIT) begin
          next_tx = 1'b0;
        end
      end
      if (maint && !(i_tx_fbit && ovr)) begin
        next_tx = maint_bit;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_line     <= 1'b1;
      o_tx_sbit_stb <= 1'b0;
      o_tx_sbit     <= 1'b0;
    end else if (i_ce) begin
      if (i_tx_bit_en) begin
        o_tx_line <= next_tx;
      end
      o_tx_sbit_stb <= link[t1_ctrl_pkg::LK_ALIGN] && i_tx_bit_en && !i_tx_fbit
                       && i_tx_slot == t1_ctrl_pkg::SYNC_SLOT && i_tx_bit_idx == 3'h0;
      o_tx_sbit     <= i_backplane_data_in;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_backplane_data_out <= 1'b0;
    end else if (i_ce && i_rx_bit_en) begin
      o_backplane_data_out <= pass ? i_rx_line_bit : i_rx_framed_bit;
    end
  end

  // An error arriving with a clearing write still counts.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      errcnt <= 8'h00;
      hist   <= 5'h00;
    end else if (i_ce) begin
      if (err_hit) begin
        errcnt <= (wr_cnt ? 8'h00 : errcnt) + 8'h01;
      end else if (wr_cnt) begin
        errcnt <= 8'h00;
      end
      if (i_rx_fbit_en) begin
        hist <= {hist[3:0], err_hit};
      end
    end
  end

  // The detect flag is cleared by reading status; a new one wins.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sec_flag <= 1'b0;
    end else if (i_ce) begin
      if (sec_hit) begin
        sec_flag <= 1'b1;
      end else if (rd_stat) begin
        sec_flag <= 1'b0;
      end
    end
  end

  // Host-forced reframes fire on the rising edge only, so the bit must return to zero first.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      resync_d           <= 1'b0;
      mf_d               <= 1'b0;
      o_frame_resync     <= 1'b0;
      o_mf_resync        <= 1'b0;
      o_sig_freeze       <= 1'b0;
      o_crc_sbit_include <= 1'b0;
      o_ch24_rate_64     <= 1'b0;
    end else if (i_ce) begin
      resync_d           <= framing[t1_ctrl_pkg::FM_RESYNC];
      mf_d               <= framing[t1_ctrl_pkg::FM_MF];
      o_frame_resync     <= force_edge || auto_re;
      o_mf_resync        <= mf_edge;
      if (mf_edge) begin
        o_sig_freeze <= 1'b1;
      end else if (i_mf_sync_ok) begin
        o_sig_freeze <= 1'b0;
      end
      o_crc_sbit_include <= link[t1_ctrl_pkg::LK_JAPAN];
      o_ch24_rate_64     <= link[t1_ctrl_pkg::LK_RATE64];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  wire tx_go = i_ce && i_tx_bit_en && !pass;
  sequence s_rd_alarm;
    i_ce && i_rd && i_addr == t1_ctrl_pkg::ADDR_ALARM;
  endsequence
  sequence s_rd_answer;
    ##1 o_rdata == $past(alarm);
  endsequence

  chk_rd_alarm: assert property (s_rd_alarm |-> s_rd_answer)
    else $error("alarm word read back wrong");
  chk_all_ones: assert property (tx_go && ones && !i_tx_fbit |=> o_tx_line)
    else $error("all ones not sent");
  chk_loop_up: assert property (
    tx_go && !ones && lup && !i_tx_fbit |=> o_tx_line == ($past(lup_cnt) == 3'h4))
    else $error("loop up code wrong");
  chk_loop_down: assert property (
    tx_go && !ones && !lup && ldn && !i_tx_fbit |=> o_tx_line == ($past(ldn_cnt) == 2'h2))
    else $error("loop down code wrong");
  chk_overlay_on: assert property (
    tx_go && maint && ovr && i_tx_fbit && !fdl_pos && !fs_pos
    |=> o_tx_line == $past(i_backplane_data_in))
    else $error("overhead not overlaid");
  chk_d4_yellow: assert property (
    tx_go && !maint && !i_tx_fbit && alarm[t1_ctrl_pkg::AL_D4_YEL] && i_tx_bit_idx == 3'h1
    |=> !o_tx_line)
    else $error("bit 2 not forced low");
  chk_pass_thru: assert property (
    i_ce && i_tx_bit_en && pass |=> o_tx_line == $past(i_backplane_data_in))
    else $error("transparent data altered");
  chk_resync_pulse: assert property (i_ce && force_edge |=> o_frame_resync)
    else $error("reframe not started");
  chk_mf_only: assert property (
    i_ce && mf_edge && !force_edge && !auto_re
    |=> o_mf_resync && !o_frame_resync && o_sig_freeze)
    else $error("multiframe reframe disturbed frame sync");
  chk_sec_flag: assert property (i_ce && sec_hit |=> sec_flag)
    else $error("secondary yellow not flagged");
  chk_f12_excluded: assert property (
    i_ce && i_rx_fbit_en && !esf && rx_fs && rx_f12 && sec_md && !wr_cnt |=> $stable(errcnt))
    else $error("frame 12 Fs counted");
  chk_fs_counted: assert property (
    i_ce && i_rx_fbit_en && i_rx_fbit_err && rx_d4 && rx_fs && fs_ok && !wr_cnt
    |=> errcnt == $past(errcnt) + 8'h01)
    else $error("errored Fs not counted");
  chk_esf_yellow: assert property (
    tx_go && !maint && fdl_pos && alarm[t1_ctrl_pkg::AL_ESF_YEL]
    |=> o_tx_line == ($past(link[t1_ctrl_pkg::LK_JAPAN]) || !$past(fdl_cnt[3])))
    else $error("yellow pattern wrong on data link");
  chk_sec_send: assert property (
    tx_go && !maint && fs_pos && alarm[t1_ctrl_pkg::AL_SEC_TX]
    && i_tx_frame == t1_ctrl_pkg::SEC_FRAME |=> o_tx_line)
    else $error("secondary alarm bit not sent");
  chk_ext_link: assert property (
    tx_go && !maint && fs_pos && link[t1_ctrl_pkg::LK_EXT]
    && i_tx_frame != t1_ctrl_pkg::SEC_FRAME |=> o_tx_line == $past(i_ext_link_bit))
    else $error("external link bit not inserted");
  chk_ch24_route: assert property (
    tx_go && !maint && !i_tx_fbit && !alarm[t1_ctrl_pkg::AL_D4_YEL]
    && link[t1_ctrl_pkg::LK_CH24_H] && i_tx_slot == t1_ctrl_pkg::CH24_SLOT
    && (link[t1_ctrl_pkg::LK_RATE64] || i_tx_bit_idx != 3'h7)
    |=> o_tx_line == $past(i_ch24_ctrl_bit))
    else $error("channel 24 link bit not inserted");
  chk_ch24_stuff: assert property (
    tx_go && !maint && !i_tx_fbit && !alarm[t1_ctrl_pkg::AL_D4_YEL]
    && link[t1_ctrl_pkg::LK_CH24_H] && !link[t1_ctrl_pkg::LK_RATE64]
    && i_tx_slot == t1_ctrl_pkg::CH24_SLOT && i_tx_bit_idx == 3'h7
    |=> o_tx_line == $past(i_backplane_data_in))
    else $error("stuffed bit taken by channel 24 link");

endmodule : t1_ctrl

// ==== verification/t1_line_model.sv ====
// Line framing path and backplane stream model feeding the control block.
`timescale 1ns/100ps
module t1_line_model (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  output logic       o_bit_en,
  output logic       o_fbit,
  output logic [4:0] o_frame,
  output logic [4:0] o_slot,
  output logic [2:0] o_idx,
  output logic       o_bp,
  output logic       o_ext,
  output logic       o_rx_line
);
  // One bit every second cycle: the F bit, slots 0 to 23, then slot 31 bit 0.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bit_en  <= 1'b0;
      o_fbit    <= 1'b1;
      o_frame   <= 5'h01;
      o_slot    <= 5'h00;
      o_idx     <= 3'h0;
      o_bp      <= 1'b0;
      o_ext     <= 1'b0;
      o_rx_line <= 1'b0;
    end else begin
      o_bit_en <= ~o_bit_en;
      if (o_bit_en) begin
        o_bp      <= 1'($urandom);
        o_ext     <= 1'($urandom);
        o_rx_line <= 1'($urandom);
        if (o_fbit) begin
          o_fbit <= 1'b0;
          o_slot <= 5'h00;
          o_idx  <= 3'h0;
        end else if (o_slot == 5'h1f) begin
          o_fbit  <= 1'b1;
          o_frame <= (o_frame == 5'h0c) ? 5'h01 : o_frame + 5'h01;
        end else if (o_idx == 3'h7) begin
          o_idx  <= 3'h0;
          o_slot <= (o_slot == 5'h17) ? 5'h1f : o_slot + 5'h01;
        end else begin
          o_idx <= o_idx + 3'h1;
        end
      end
    end
  end
endmodule : t1_line_model

// ==== verification/testbench.sv ====
// Self-checking bench for the T1 framing, alarm and data link control block.
`timescale 1ns/100ps
module testbench;
  logic       i_mclk, i_rst, i_wr, i_rd, fb_en, rx_fb, rx_err, mf_ok;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [4:0] rx_fr, tx_fr, tx_sl;
  logic [2:0] tx_ix;
  logic       tx_en, tx_fb, bp, ext, rx_line, tx_line, stb, sbit, bp_out;
  logic       rsy, mrsy, frz, crc, r64;
  int         miscompares, samples_checked;
  t1_line_model line (.i_mclk(i_mclk), .i_rst(i_rst), .o_bit_en(tx_en), .o_fbit(tx_fb),
    .o_frame(tx_fr), .o_slot(tx_sl), .o_idx(tx_ix), .o_bp(bp), .o_ext(ext),
    .o_rx_line(rx_line));
  t1_ctrl dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_bit_en(tx_en),
    .i_tx_fbit(tx_fb), .i_tx_frame(tx_fr), .i_tx_slot(tx_sl), .i_tx_bit_idx(tx_ix),
    .i_backplane_data_in(bp), .i_ext_link_bit(ext), .i_fdl_ctrl_bit(ext),
    .i_ch24_ctrl_bit(~bp), .o_tx_line(tx_line), .o_tx_sbit_stb(stb), .o_tx_sbit(sbit),
    .i_rx_fbit_en(fb_en), .i_rx_frame(rx_fr), .i_rx_fbit(rx_fb), .i_rx_fbit_err(rx_err),
    .i_mf_sync_ok(mf_ok), .i_rx_bit_en(tx_en), .i_rx_line_bit(rx_line),
    .i_rx_framed_bit(~rx_line), .o_backplane_data_out(bp_out), .o_frame_resync(rsy),
    .o_mf_resync(mrsy), .o_sig_freeze(frz), .o_crc_sbit_include(crc),
    .o_ch24_rate_64(r64));
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk_reg(o_rdata, e);
  endtask : rdc
  task automatic rf(input logic [7:0] d, input logic e);
    wr(8'h10, d);
    @(posedge i_mclk);
    #1 chk_bit(d[0] ? mrsy : rsy, e);
  endtask : rf
  task automatic rxf(input logic [4:0] fr, input logic v);
    @(posedge i_mclk);
    fb_en  <= 1'b1;
    rx_fr  <= fr;
    rx_fb  <= v;
    rx_err <= 1'b1;
    @(posedge i_mclk);
    fb_en <= 1'b0;
  endtask : rxf
  // Modes: 0 all ones, 1 transparent, 2 yellow, 3 count ones, 4 framed all ones,
  // 5 D4 link and channel 24 at 56k, 6 ESF yellow with Japan option, 7 FDL controller.
  function automatic logic exp_tx(input int m, input logic b, input logic [2:0] ix,
                                  input logic f, input logic [4:0] fr,
                                  input logic [4:0] s, input logic e);
    case (m)
      0: return 1'b1;
      1: return b;
      2: return (ix == 3'h1) ? 1'b0 : b;
      5: begin
        if (f && !fr[0]) return (fr == 5'h0c) ? 1'b1 : e;
        return (!f && s == 5'h17 && ix != 3'h7) ? ~b : b;
      end
      6: return (f && fr[0]) ? 1'b1 : b;
      7: return (f && fr[0]) ? e : b;
      default: return f ? b : 1'b1;
    endcase
  endfunction : exp_tx
  task automatic watch(input int n, input int m, input logic [7:0] ones_exp);
    logic       b, f, r, e;
    logic [4:0] s, fr;
    logic [2:0] ix;
    int         k;
    int         ones;
    ones = 0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge i_mclk);
        #1 k++;
      end while (tx_en !== 1'b1 && k < 8);
      if (k >= 8) begin
        miscompares++;
        print_verdict();
      end
      b = bp;
      f = tx_fb;
      r = rx_line;
      s = tx_sl;
      ix = tx_ix;
      e = ext;
      fr = tx_fr;
      @(posedge i_mclk);
      #1 ones += int'(tx_line === 1'b1);
      if (m != 3 && (m == 0 || m >= 4 || (!f && (m == 1 || s != 5'h1f))))
        chk_bit(tx_line, exp_tx(m, b, ix, f, fr, s, e));
      if (m == 1 && !f) chk_bit(bp_out, r);
      if (m == 1 && !f && s == 5'h1f) chk_bit(stb & (sbit === b), 1'b1);
    end
    if (m == 3) chk_reg(8'(ones), ones_exp);
  endtask : watch
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    logic [7:0] d;
    logic [7:0] a;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    fb_en = 1'b0;
    rx_fr = 5'h01;
    rx_fb = 1'b0;
    rx_err = 1'b0;
    mf_ok = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'h1a69));
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    rdc(8'h10, t1_ctrl_pkg::FRAMING_RST);
    rdc(8'h11, t1_ctrl_pkg::ALARM_RST);
    rdc(8'h12, t1_ctrl_pkg::LINK_RST);
    rdc(8'h13, t1_ctrl_pkg::MSG_RST);
    wr(8'h55, 8'hff);
    rdc(8'h55, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      a = 8'h10 + 8'(i % 4);
      wr(a, d);
      rdc(a, d);
    end
    wr(8'h11, 8'h10);
    wr(8'h12, 8'h00);
    rf(8'h00, 1'b0);
    rf(8'h02, 1'b1);
    rf(8'h02, 1'b0);
    rf(8'h00, 1'b0);
    rf(8'h02, 1'b1);
    rf(8'h00, 1'b0);
    rf(8'h01, 1'b1);
    #1 chk_bit(frz & ~rsy, 1'b1);
    @(posedge i_mclk);
    mf_ok <= 1'b1;
    @(posedge i_mclk);
    mf_ok <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 chk_bit(frz, 1'b0);
    rf(8'h80, 1'b0);
    rf(8'h81, 1'b0);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h00);
    watch(40, 0, 8'h00);
    wr(8'h11, 8'h01);
    watch(400, 4, 8'h00);
    wr(8'h11, 8'h18);
    watch(15, 3, 8'h03);
    wr(8'h11, 8'h14);
    watch(15, 3, 8'h05);
    wr(8'h11, 8'h30);
    watch(60, 2, 8'h00);
    wr(8'h11, 8'h10);
    wr(8'h12, 8'h0f);
    watch(250, 1, 8'h00);
    chk_bit(crc & r64, 1'b1);
    wr(8'h12, 8'h00);
    @(posedge i_mclk);
    #1 chk_bit(crc | r64, 1'b0);
    wr(8'h11, 8'h50);
    wr(8'h12, 8'h90);
    watch(2400, 5, 8'h00);
    wr(8'h10, 8'h80);
    wr(8'h11, 8'h90);
    wr(8'h12, 8'h02);
    watch(400, 6, 8'h00);
    wr(8'h11, 8'h10);
    wr(8'h12, 8'h20);
    watch(400, 7, 8'h00);
    wr(8'h10, 8'h1c);
    wr(t1_ctrl_pkg::ADDR_ERRCNT, 8'h00);
    rxf(5'h02, 1'b0);
    rxf(5'h0c, 1'b0);
    rdc(t1_ctrl_pkg::ADDR_ERRCNT, 8'h02);
    wr(8'h11, 8'h12);
    rxf(5'h0c, 1'b1);
    rdc(t1_ctrl_pkg::ADDR_ERRCNT, 8'h02);
    rdc(t1_ctrl_pkg::ADDR_STATUS, 8'h01);
    rdc(t1_ctrl_pkg::ADDR_STATUS, 8'h00);
    wr(8'h10, 8'h18);
    rxf(5'h04, 1'b0);
    rdc(t1_ctrl_pkg::ADDR_ERRCNT, 8'h02);
    wr(8'h10, 8'h0c);
    rxf(5'h02, 1'b0);
    rxf(5'h04, 1'b0);
    #1 chk_bit(rsy, 1'b1);
    print_verdict();
  end
endmodule : testbench
